// File: board_pins_model.sv
// Purpose: Board logic on the far side of the sixteen pads
// Assumes: The board drives every pad that the port leaves undriven
// Notes:   The port wins wherever its enable is high
`timescale 1ns/1ps
module board_pins_model (
	// Pad drive from the port
	input  wire logic [15:0] pin_o,
	input  wire logic [15:0] pin_oe,
	// Levels the board puts on free pads
	input  wire logic [15:0] board_val,
	// Resolved wire levels
	output logic [15:0]      pin_i
);
	// Resolve each wire from the port's enable alone
	assign pin_i = (pin_oe & pin_o) | (~pin_oe & board_val);
endmodule : board_pins_model

// File: gpio_mux_consts.svh
// Purpose: Register offsets, field positions and reset values of the pin mux port
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Definitions only
`ifndef GPIO_MUX_CONSTS_SVH
`define GPIO_MUX_CONSTS_SVH

`define GPIO_OFS        12'h000
`define WDOG_CTRL_OFS   12'h004
`define MUX_SEL_OFS     12'h008
`define CTRL_OFS        12'h00C

`define GPIO_OUT_LSB    0
`define GPIO_DIR_LSB    16
`define GPIO_IN_LSB     0

`define SEL_XF_LSB      0
`define SEL_BIO_LSB     4
`define SEL_TOUT_LSB    8
`define WDOG_SEL_LSB    0
`define CTRL_FLOAT_BIT  0

`define GPIO_OUT_RST    16'h0000
`define GPIO_DIR_RST    16'h0000
`define WDOG_SEL_RST    4'h0
`define SEL_RST         4'h0
`define FLOAT_EN_RST    1'b0

`endif

// File: gpio_mux_pkg.sv
// Purpose: Types shared by the pin mux port
// Assumes: Four subsystems, four pins each
// Notes:   Constants live in gpio_mux_consts.svh
package gpio_mux_pkg;
	typedef logic [15:0] pin_vec_t;
	typedef logic [3:0]  sub_vec_t;
	typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_ACCESS} apb_phase_t;
endpackage : gpio_mux_pkg

// File: pin_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for one pin level
// Assumes: Input is asynchronous to pclk
// Notes:   The first stage feeds only the second stage
`timescale 1ns/1ps
module pin_sync (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Level in and filtered level out
	input  wire logic pin_in,
	output logic      level_out
);
	logic s1_reg, s2_reg, s3_reg, lvl_reg;
	logic lvl_next;

	// Accept a change only once stages two and three agree
	always_comb begin
		lvl_next = lvl_reg;
		if (s2_reg == s3_reg) begin
			lvl_next = s3_reg;
		end
	end

	// Shift chain and filtered level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_reg  <= 1'b0;
			s2_reg  <= 1'b0;
			s3_reg  <= 1'b0;
			lvl_reg <= 1'b0;
		end else begin
			s1_reg  <= pin_in;
			s2_reg  <= s1_reg;
			s3_reg  <= s2_reg;
			lvl_reg <= lvl_next;
		end
	end

	assign level_out = lvl_reg;
endmodule : pin_sync

// File: subsystem_gpio_pin_mux.sv
// Purpose: Four-subsystem general-purpose pin port with peripheral multiplexing
// Assumes: APB slave on pclk; pin inputs asynchronous; peripheral signals on pclk
// Notes:   Pin index 4*s+n is pin n of subsystem s
`timescale 1ns/1ps
`include "gpio_mux_consts.svh"

// Overview of operation
// - Flag select set drives subsystem external flag on pin zero, else ordinary I/O.
// - Branch select set feeds pin one level to branch input, else ordinary I/O.
// - Watchdog output select in watchdog control register picks watchdog on pin two.
// - Timer select set drives subsystem timer output on pin three, else ordinary I/O.
// - Written output values are latched and driven on pins set as outputs.
// - Reading the port register returns sampled levels of pins set as inputs.
// - Each pin without a peripheral selected takes its direction from its own software-writable direction field.
// - Emulation float control low with float enabled tristates every pin.
// - Each subsystem has its own four pins and independent select bits.
module subsystem_gpio_pin_mux
	import gpio_mux_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Peripheral signals of the four subsystems
	input  wire logic [3:0]  ext_flag,
	input  wire logic [3:0]  wdog_out,
	input  wire logic [3:0]  timer_out,
	output logic [3:0]       branch_ctrl,
	// Emulation float control pin
	input  wire logic        emu_float_ctl_n,
	// Pads
	input  wire logic [15:0] pin_i,
	output logic [15:0]      pin_o,
	output logic [15:0]      pin_oe
);
	pin_vec_t out_reg, out_next;
	pin_vec_t dir_reg, dir_next;
	sub_vec_t xf_sel_reg, xf_sel_next;
	sub_vec_t bio_sel_reg, bio_sel_next;
	sub_vec_t tout_sel_reg, tout_sel_next;
	sub_vec_t wd_sel_reg, wd_sel_next;
	logic     float_en_reg, float_en_next;
	logic [31:0] rdata_reg, rdata_next;
	logic     err_reg, err_next;
	logic     float_lvl;
	pin_vec_t pin_lvl;
	pin_vec_t per_sel;
	pin_vec_t per_val;
	pin_vec_t per_oe;
	logic     wr_en, rd_en;

	// Address decode shared by read and write paths
	function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] ofs);
		addr_hit = (a == ofs);
	endfunction : addr_hit

	function automatic logic addr_known(input logic [11:0] a);
		addr_known = addr_hit(a, `GPIO_OFS) || addr_hit(a, `WDOG_CTRL_OFS) ||
			addr_hit(a, `MUX_SEL_OFS) || addr_hit(a, `CTRL_OFS);
	endfunction : addr_known

	// Access phase is answered in the same cycle
	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && !penable && !pwrite;
	assign pready  = 1'b1;
	assign pslverr = err_reg;
	assign prdata  = rdata_reg;

	// Synchronise every pad input and the float control
	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_sync
			pin_sync u_sync (
				.pclk      (pclk),
				.presetn   (presetn),
				.pin_in    (pin_i[g]),
				.level_out (pin_lvl[g])
			);
		end
	endgenerate

	pin_sync u_float_sync (
		.pclk      (pclk),
		.presetn   (presetn),
		.pin_in    (emu_float_ctl_n),
		.level_out (float_lvl)
	);

	// Register writes; peripheral selection never touches the output latch
	always_comb begin
		out_next      = out_reg;
		dir_next      = dir_reg;
		xf_sel_next   = xf_sel_reg;
		bio_sel_next  = bio_sel_reg;
		tout_sel_next = tout_sel_reg;
		wd_sel_next   = wd_sel_reg;
		float_en_next = float_en_reg;
		if (wr_en) begin
			if (addr_hit(paddr, `GPIO_OFS)) begin
				out_next = pwdata[`GPIO_OUT_LSB +: 16];
				dir_next = pwdata[`GPIO_DIR_LSB +: 16];
			end
			if (addr_hit(paddr, `WDOG_CTRL_OFS)) begin
				wd_sel_next = pwdata[`WDOG_SEL_LSB +: 4];
			end
			if (addr_hit(paddr, `MUX_SEL_OFS)) begin
				xf_sel_next   = pwdata[`SEL_XF_LSB +: 4];
				bio_sel_next  = pwdata[`SEL_BIO_LSB +: 4];
				tout_sel_next = pwdata[`SEL_TOUT_LSB +: 4];
			end
			if (addr_hit(paddr, `CTRL_OFS)) begin
				float_en_next = pwdata[`CTRL_FLOAT_BIT];
			end
		end
	end

	// Read data captured in the setup cycle, error flagged for unmapped addresses
	always_comb begin
		rdata_next = rdata_reg;
		err_next   = 1'b0;
		if (psel && !penable) begin
			err_next = !addr_known(paddr);
		end
		if (rd_en) begin
			rdata_next = 32'h0000_0000;
			if (addr_hit(paddr, `GPIO_OFS)) begin
				rdata_next[`GPIO_IN_LSB +: 16]  = pin_lvl & ~dir_reg;
				rdata_next[`GPIO_DIR_LSB +: 16] = dir_reg;
			end
			if (addr_hit(paddr, `WDOG_CTRL_OFS)) begin
				rdata_next[`WDOG_SEL_LSB +: 4] = wd_sel_reg;
			end
			if (addr_hit(paddr, `MUX_SEL_OFS)) begin
				rdata_next[`SEL_XF_LSB +: 4]   = xf_sel_reg;
				rdata_next[`SEL_BIO_LSB +: 4]  = bio_sel_reg;
				rdata_next[`SEL_TOUT_LSB +: 4] = tout_sel_reg;
			end
			if (addr_hit(paddr, `CTRL_OFS)) begin
				rdata_next[`CTRL_FLOAT_BIT] = float_en_reg;
			end
		end
	end

	// Register state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_reg      <= `GPIO_OUT_RST;
			dir_reg      <= `GPIO_DIR_RST;
			xf_sel_reg   <= `SEL_RST;
			bio_sel_reg  <= `SEL_RST;
			tout_sel_reg <= `SEL_RST;
			wd_sel_reg   <= `WDOG_SEL_RST;
			float_en_reg <= `FLOAT_EN_RST;
			rdata_reg    <= 32'h0000_0000;
			err_reg      <= 1'b0;
		end else begin
			out_reg      <= out_next;
			dir_reg      <= dir_next;
			xf_sel_reg   <= xf_sel_next;
			bio_sel_reg  <= bio_sel_next;
			tout_sel_reg <= tout_sel_next;
			wd_sel_reg   <= wd_sel_next;
			float_en_reg <= float_en_next;
			rdata_reg    <= rdata_next;
			err_reg      <= err_next;
		end
	end

	// Per-subsystem peripheral routing, each set on its own selects
	genvar s;
	generate
		for (s = 0; s < 4; s++) begin : g_sub
			assign per_sel[4*s+0] = xf_sel_reg[s];
			assign per_val[4*s+0] = ext_flag[s];
			assign per_oe[4*s+0]  = 1'b1;
			assign per_sel[4*s+1] = bio_sel_reg[s];
			assign per_val[4*s+1] = 1'b0;
			assign per_oe[4*s+1]  = 1'b0;
			assign per_sel[4*s+2] = wd_sel_reg[s];
			assign per_val[4*s+2] = wdog_out[s];
			assign per_oe[4*s+2]  = 1'b1;
			assign per_sel[4*s+3] = tout_sel_reg[s];
			assign per_val[4*s+3] = timer_out[s];
			assign per_oe[4*s+3]  = 1'b1;
			// Branch input sees pin one level only when selected
			assign branch_ctrl[s] = bio_sel_reg[s] & pin_lvl[4*s+1];
		end
	endgenerate

	// Pad drive with float override
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			pin_o[i]  = per_sel[i] ? per_val[i] : out_reg[i];
			pin_oe[i] = per_sel[i] ? per_oe[i] : dir_reg[i];
			if (float_en_reg && !float_lvl) begin
				pin_oe[i] = 1'b0;
			end
		end
	end

	// Float override currently in force, shared by the assertions below
	logic     float_now;
	assign float_now = float_en_reg && !float_lvl;

	// Assertions
	sequence s_float_active;
		float_en_reg && !float_lvl;
	endsequence

	a_float_tristate: assert property (@(posedge pclk) disable iff (!presetn)
		s_float_active |-> (pin_oe == 16'h0000))
		else $error("pins driven while floated");

	a_flag_route: assert property (@(posedge pclk) disable iff (!presetn)
		(xf_sel_reg[0] && !float_now) |-> (pin_o[0] == ext_flag[0] && pin_oe[0]))
		else $error("flag not on pin zero");

	a_branch_route: assert property (@(posedge pclk) disable iff (!presetn)
		branch_ctrl[3] |-> (bio_sel_reg[3] && pin_lvl[13] && !pin_oe[13]))
		else $error("branch input misrouted");

	a_wdog_route: assert property (@(posedge pclk) disable iff (!presetn)
		(!wd_sel_reg[2]) |-> (pin_o[10] == out_reg[10]))
		else $error("watchdog on pin without select");

	a_timer_route: assert property (@(posedge pclk) disable iff (!presetn)
		(tout_sel_reg[2] && !float_now) |-> (pin_o[11] == timer_out[2] && pin_oe[11]))
		else $error("timer not on pin three");

	a_write_latch: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && addr_hit(paddr, `GPIO_OFS)) |=> (out_reg == $past(pwdata[15:0])))
		else $error("output latch not written");

	a_read_input: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_en && addr_hit(paddr, `GPIO_OFS)) |=> (prdata[15:0] == ($past(pin_lvl) & ~$past(dir_reg))))
		else $error("read data not input levels");

	a_dir_field: assert property (@(posedge pclk) disable iff (!presetn)
		(per_sel == 16'h0000 && !float_now) |-> (pin_oe == dir_reg))
		else $error("direction not followed");

	a_latch_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(!wr_en && $changed(xf_sel_reg)) |-> $stable(out_reg))
		else $error("latch changed by select");

	a_branch_gate: assert property (@(posedge pclk) disable iff (!presetn)
		(!bio_sel_reg[3]) |-> (branch_ctrl[3] == 1'b0))
		else $error("branch input leaks without select");

	a_branch_level: assert property (@(posedge pclk) disable iff (!presetn)
		bio_sel_reg[3] |-> (branch_ctrl[3] == pin_lvl[13] && !pin_oe[13]))
		else $error("branch input not pin level");

	a_flag_off: assert property (@(posedge pclk) disable iff (!presetn)
		(!xf_sel_reg[0]) |-> (pin_o[0] == out_reg[0]))
		else $error("flag on pin without select");

	a_timer_off: assert property (@(posedge pclk) disable iff (!presetn)
		(!tout_sel_reg[2]) |-> (pin_o[11] == out_reg[11]))
		else $error("timer on pin without select");

	a_wdog_on: assert property (@(posedge pclk) disable iff (!presetn)
		(wd_sel_reg[1] && !float_now) |-> (pin_o[6] == wdog_out[1] && pin_oe[6]))
		else $error("watchdog not on pin two");

	a_wdog_isolate: assert property (@(posedge pclk) disable iff (!presetn)
		(wd_sel_reg[1] && !wd_sel_reg[0]) |-> (pin_o[2] == out_reg[2]))
		else $error("watchdog select crossed subsystems");

	a_flag_isolate: assert property (@(posedge pclk) disable iff (!presetn)
		(xf_sel_reg[0] && !xf_sel_reg[1]) |-> (pin_o[4] == out_reg[4]))
		else $error("flag select crossed subsystems");

	a_dir_pin_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(!xf_sel_reg[0] && !float_now) |-> (pin_oe[0] == dir_reg[0]))
		else $error("pin zero direction not followed");

	a_latch_timer: assert property (@(posedge pclk) disable iff (!presetn)
		(!wr_en && $changed(tout_sel_reg)) |-> $stable(out_reg))
		else $error("latch changed by timer select");

	a_dir_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && addr_hit(paddr, `GPIO_OFS)) |=> (dir_reg == $past(pwdata[31:16])))
		else $error("direction field not written");

	a_dir_read: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_en && addr_hit(paddr, `GPIO_OFS)) |=> (prdata[31:16] == $past(dir_reg)))
		else $error("direction field not read back");
endmodule : subsystem_gpio_pin_mux

// File: subsystem_gpio_pin_mux_tb_top.sv
// Purpose: Self-checking bench for the pin mux port
// Assumes: Zero-wait APB slave; pad inputs filtered by a few edges
// Notes:   Each scenario is a task that judges its own results
`timescale 1ns/1ps
`include "gpio_mux_consts.svh"
module subsystem_gpio_pin_mux_tb_top;
	import gpio_mux_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, emu_n, re;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  ext_flag, wdog_out, timer_out, branch_ctrl;
	pin_vec_t    pin_i, pin_o, pin_oe, board_val;
	int          err_count, tests_run;

	subsystem_gpio_pin_mux i_subsystem_gpio_pin_mux (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_flag(ext_flag),
		.wdog_out(wdog_out), .timer_out(timer_out), .branch_ctrl(branch_ctrl),
		.emu_float_ctl_n(emu_n), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe));
	board_pins_model i_board_pins_model (.pin_o(pin_o), .pin_oe(pin_oe),
		.board_val(board_val), .pin_i(pin_i));

	// Clock at 100 MHz
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Closing report
	task automatic wrap_up;
		$display("Checks %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : wrap_up

	// Compare one value
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask : cyc

	// One APB transfer; holds the request until pready is seen high or 50 access cycles pass
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		re = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		if (n >= 50) begin
			err_count++;
			wrap_up();
		end
		@(posedge pclk);
	endtask : apb

	// Reset state of pads and registers
	task automatic t_reset;
		chk("oe", 32'h0, pin_oe);
		apb(0, `GPIO_OFS, 32'h0); chk("port", 32'h0, rd);
		chk("slverr", 32'h0, re);
		apb(0, `MUX_SEL_OFS, 32'h0); chk("sel", 32'h0, rd);
		apb(0, `WDOG_CTRL_OFS, 32'h0); chk("wdog", 32'h0, rd);
	endtask : t_reset

	// Outputs latch and drive; output pins read 0
	task automatic t_out;
		apb(1, `GPIO_OFS, 32'hFFFF_A5C3);
		chk("oe", 32'hFFFF, pin_oe);
		chk("pin_o", 32'hA5C3, pin_o);
		apb(0, `GPIO_OFS, 32'h0); chk("port", 32'hFFFF_0000, rd);
	endtask : t_out

	// Input pins sampled by a read
	task automatic t_in;
		board_val <= 16'h1234;
		apb(1, `GPIO_OFS, 32'h0000_FFFF);
		cyc(6);
		chk("oe", 32'h0, pin_oe);
		apb(0, `GPIO_OFS, 32'h0); chk("port", 32'h0000_1234, rd);
	endtask : t_in

	// Peripheral selects on pins 0, 2, 3 of different subsystems
	task automatic t_mux;
		ext_flag <= 4'hF; wdog_out <= 4'hF; timer_out <= 4'hF;
		apb(1, `GPIO_OFS, 32'hFFFF_0002);
		apb(1, `MUX_SEL_OFS, 32'h0000_0401);
		apb(1, `WDOG_CTRL_OFS, 32'h2);
		chk("pin_o", 32'h0843, pin_o);
		ext_flag <= 4'h0;
		cyc(1);
		chk("pin_o", 32'h0842, pin_o);
		apb(1, `MUX_SEL_OFS, 32'h0); apb(1, `WDOG_CTRL_OFS, 32'h0);
		chk("pin_o", 32'h0002, pin_o);
	endtask : t_mux

	// Branch control input from pin one of subsystem 3
	task automatic t_bio;
		apb(1, `GPIO_OFS, 32'h0);
		board_val <= 16'h2000;
		apb(1, `MUX_SEL_OFS, 32'h0000_0080);
		cyc(6);
		chk("branch", 32'h8, branch_ctrl);
		chk("oe", 32'h0, pin_oe);
		apb(1, `MUX_SEL_OFS, 32'h0);
		chk("branch", 32'h0, branch_ctrl);
	endtask : t_bio

	// Emulation float tristates all pins
	task automatic t_float;
		apb(1, `GPIO_OFS, 32'hFFFF_0000);
		apb(1, `CTRL_OFS, 32'h1);
		emu_n <= 1'b0;
		cyc(6);
		chk("oe", 32'h0, pin_oe);
		emu_n <= 1'b1;
		cyc(6);
		chk("oe", 32'hFFFF, pin_oe);
	endtask : t_float

	// Unmapped address is refused
	task automatic t_bad;
		apb(0, 12'h010, 32'h0);
		chk("rdata", 32'h0, rd);
		chk("slverr", 32'h1, re);
	endtask : t_bad

	// Main sequence
	initial begin
		err_count = 0; tests_run = 0;
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 12'h000; pwdata = 32'h0; emu_n = 1'b1; board_val = 16'h0000;
		ext_flag = 4'h0; wdog_out = 4'h0; timer_out = 4'h0;
		cyc(4);
		presetn <= 1'b1;
		cyc(1);
		t_reset(); t_out(); t_in(); t_mux(); t_bio(); t_float(); t_bad();
		wrap_up();
	end
endmodule : subsystem_gpio_pin_mux_tb_top
